/* src/pfsm_pkg.sv */
// Purpose: Shared constants and types for the pin function select mux
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Register byte address is four times the register index

package pfsm_pkg;

  // ************************************************************
  // Bus and register geometry
  // ************************************************************
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned REG_W  = 16;

  localparam logic [15:0] IDX_EXT_BUS_SELECT      = 16'h1C00;
  localparam logic [15:0] IDX_ROUTE_STATUS        = 16'h1C01;
  localparam logic [15:0] IDX_OUTPUT_SLEW_SELECT  = 16'h1C16;
  localparam logic [15:0] IDX_PULL_INHIBIT_FIRST  = 16'h1C17;
  localparam logic [15:0] IDX_PULL_INHIBIT_SECOND = 16'h1C18;
  localparam logic [15:0] IDX_PULL_INHIBIT_THIRD  = 16'h1C19;

  localparam logic [15:0] ADDR_EXT_BUS_SELECT      = 16'(IDX_EXT_BUS_SELECT << 2);
  localparam logic [15:0] ADDR_OUTPUT_SLEW_SELECT  = 16'(IDX_OUTPUT_SLEW_SELECT << 2);
  localparam logic [15:0] ADDR_PULL_INHIBIT_FIRST  = 16'(IDX_PULL_INHIBIT_FIRST << 2);

  // ************************************************************
  // Field layout and reset values
  // ************************************************************
  localparam int unsigned MODE_LSB   = 12;
  localparam int unsigned MODE_W     = 3;
  localparam int unsigned ADDR_SEL_N = 6;

  // In the selection register only the route mode and address-pin selects are writable
  localparam logic [15:0] EXT_BUS_SELECT_WR_MASK = 16'h703F;
  localparam logic [15:0] EXT_BUS_SELECT_RST     = 16'h0000;
  localparam logic [15:0] SLEW_WR_MASK           = 16'h0003;
  localparam logic [15:0] SLEW_RST               = 16'h0000;
  localparam logic [15:0] PULL_RST               = 16'h0000;
  localparam int unsigned SLEW_CLOCK_OUT_BIT     = 0;
  localparam int unsigned SLEW_EXT_MEM_BIT       = 1;

  localparam int unsigned ST_DED_BIT = 0;
  localparam int unsigned ST_A_LSB   = 1;
  localparam int unsigned ST_B_LSB   = 3;

  typedef enum logic [2:0] {
    PP_MODE0 = 3'h0,
    PP_MODE1 = 3'h1,
    PP_MODE2 = 3'h2,
    PP_MODE3 = 3'h3,
    PP_MODE4 = 3'h4,
    PP_MODE5 = 3'h5,
    PP_MODE6 = 3'h6,
    PP_RSVD7 = 3'h7
  } pfsm_mode_e;

  typedef enum logic [1:0] {GRP_NONE, GRP_PRIMARY, GRP_GPL, GRP_ALT} pfsm_grp_e;

  // ************************************************************
  // Pin map of the parallel port
  // ************************************************************
  localparam int unsigned PP_PINS     = 21;
  localparam int unsigned SIF_N       = 7;
  localparam int unsigned PORT_N      = 4;
  localparam int unsigned GPL_W       = 32;
  localparam int unsigned GPL_DED_N   = 6;
  localparam int unsigned GPL_DED_FIRST = 12;
  localparam int unsigned GPL_DED_PIN0  = 3;
  localparam int unsigned GRP_A_PIN0  = 9;
  localparam int unsigned GRP_B_PIN0  = 13;
  localparam int unsigned GPL_B_FIRST = 28;
  localparam int unsigned GPL_ADDR_FIRST = 21;
  localparam int unsigned SIF_DED_PIN [SIF_N] = '{0, 17, 1, 2, 18, 19, 20};
  localparam int unsigned GPL_A [PORT_N] = '{18, 19, 20, 27};

  // Serial order: clock, select0, receive, transmit, select1..3
  localparam logic [6:0] SIF_IDLE  = 7'h72;
  localparam logic [3:0] UART_IDLE = 4'h6;
  localparam logic [3:0] AUD_IDLE  = 4'h0;

endpackage

/* src/pfsm_cfg_if.sv */
// Purpose: Register values passed from the register block to the routing
// Assumes: One clock domain
// Notes:   Status flows back for software readout
`timescale 1ns/10ps

interface pfsm_cfg_if;
  logic [15:0] ext_bus_select;
  logic [15:0] output_slew_select;
  logic [15:0] pull_inhibit_first;
  logic [15:0] pull_inhibit_second;
  logic [15:0] pull_inhibit_third;
  logic [15:0] route_status;

  modport regs (
    output ext_bus_select,
    output output_slew_select,
    output pull_inhibit_first,
    output pull_inhibit_second,
    output pull_inhibit_third,
    input  route_status
  );

  modport core (
    input  ext_bus_select,
    input  output_slew_select,
    input  pull_inhibit_first,
    input  pull_inhibit_second,
    input  pull_inhibit_third,
    output route_status
  );
endinterface

/* src/pfsm_regs.sv */
// Purpose: APB register file for the pin function select mux
// Assumes: Zero wait states; unaligned or unmapped access gives pslverr
// Notes:   Read data is captured in the setup cycle
`timescale 1ns/10ps

module pfsm_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  pfsm_cfg_if.regs         cfg
);

  // ************************************************************
  // Decode
  // ************************************************************
  logic [15:0] ebs_q, slew_q, pull1_q, pull2_q, pull3_q;
  logic [31:0] rdata_q, rdata_d;
  wire  [15:0] word_idx   = {2'h0, paddr[15:2]};
  wire         aligned    = (paddr[1:0] == 2'h0);
  wire         hit_ebs    = aligned && word_idx == pfsm_pkg::IDX_EXT_BUS_SELECT;
  wire         hit_stat   = aligned && word_idx == pfsm_pkg::IDX_ROUTE_STATUS;
  wire         hit_slew   = aligned && word_idx == pfsm_pkg::IDX_OUTPUT_SLEW_SELECT;
  wire         hit_pull1  = aligned && word_idx == pfsm_pkg::IDX_PULL_INHIBIT_FIRST;
  wire         hit_pull2  = aligned && word_idx == pfsm_pkg::IDX_PULL_INHIBIT_SECOND;
  wire         hit_pull3  = aligned && word_idx == pfsm_pkg::IDX_PULL_INHIBIT_THIRD;
  wire         hit_any    = hit_ebs | hit_stat | hit_slew | hit_pull1 | hit_pull2 | hit_pull3;
  wire         wr_en      = psel && penable && pwrite && hit_any;
  wire  [15:0] wdata      = pwdata[15:0];

  // Status is computed live; reading it never disturbs routing
  assign rdata_d = hit_ebs   ? {16'h0000, ebs_q}   :
                   hit_stat  ? {16'h0000, cfg.route_status} :
                   hit_slew  ? {16'h0000, slew_q}  :
                   hit_pull1 ? {16'h0000, pull1_q} :
                   hit_pull2 ? {16'h0000, pull2_q} :
                   hit_pull3 ? {16'h0000, pull3_q} : 32'h0000_0000;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_any;
  assign prdata  = rdata_q;

  // ************************************************************
  // Storage
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ebs_q   <= pfsm_pkg::EXT_BUS_SELECT_RST;
      slew_q  <= pfsm_pkg::SLEW_RST;
      pull1_q <= pfsm_pkg::PULL_RST;
      pull2_q <= pfsm_pkg::PULL_RST;
      pull3_q <= pfsm_pkg::PULL_RST;
    end else if (wr_en) begin
      if (hit_ebs) begin
        ebs_q <= wdata & pfsm_pkg::EXT_BUS_SELECT_WR_MASK;
      end
      if (hit_slew) begin
        slew_q <= wdata & pfsm_pkg::SLEW_WR_MASK;
      end
      if (hit_pull1) begin
        pull1_q <= wdata;
      end
      if (hit_pull2) begin
        pull2_q <= wdata;
      end
      if (hit_pull3) begin
        pull3_q <= wdata;
      end
    end
  end

  assign cfg.ext_bus_select      = ebs_q;
  assign cfg.output_slew_select  = slew_q;
  assign cfg.pull_inhibit_first  = pull1_q;
  assign cfg.pull_inhibit_second = pull2_q;
  assign cfg.pull_inhibit_third  = pull3_q;

endmodule

/* src/pfsm_top.sv */
// Purpose: Routes peripheral signals onto shared package pins
// Assumes: Pins are split into out, out-enable and in; pad logic resolves them
// Notes:   Routing is combinational from the register contents
`timescale 1ns/10ps

// What this block does
// - One selection register alone controls every shared-pin function choice.
// - Select bit 5 puts address line 20 or general line 26 on its pin.
// - Select bit 4 puts address line 19 or general line 25 on its pin.
// - Select bit 3 puts address line 18 or general line 24 on its pin.
// - Select bit 2 puts address line 17 or general line 23 on its pin.
// - Select bit 1 puts address line 16 or general line 22 on its pin.
// - Select bit 0 puts address line 15 or general line 21 on its pin.
// - Route mode codes 0 to 6; code 0 at reset routes nothing.
// - Group A pins carry audio port 2, general lines, or serial interface.
// - Group B pins carry the UART, general lines 28-31, or audio port 3.
// - Modes 1 and 6 also route seven serial signals and general lines 12-17.
// - Route mode field sits in bits 14 to 12 of the selection register.
// - Each pull resistor has its own disable bit in three registers.
// - Slew register picks fast or slow edges for clock-out and memory pins.
module pfsm_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [6:0]  sif_out,
  input  wire logic [6:0]  sif_oe,
  output logic      [6:0]  sif_in,
  input  wire logic [3:0]  ap2_out,
  input  wire logic [3:0]  ap2_oe,
  output logic      [3:0]  ap2_in,
  input  wire logic [3:0]  ap3_out,
  input  wire logic [3:0]  ap3_oe,
  output logic      [3:0]  ap3_in,
  input  wire logic [3:0]  uart_out,
  input  wire logic [3:0]  uart_oe,
  output logic      [3:0]  uart_in,
  input  wire logic [31:0] gpl_out,
  input  wire logic [31:0] gpl_oe,
  output logic      [31:0] gpl_in,
  input  wire logic [5:0]  ext_addr_out,
  input  wire logic [5:0]  ext_addr_oe,
  output logic      [20:0] pp_pin_out,
  output logic      [20:0] pp_pin_oe,
  input  wire logic [20:0] pp_pin_in,
  output logic      [5:0]  addr_pin_out,
  output logic      [5:0]  addr_pin_oe,
  input  wire logic [5:0]  addr_pin_in,
  output logic      [47:0] pull_disable,
  output logic             clock_output_pin_slow,
  output logic             ext_mem_interface_slow
);

  // ************************************************************
  // Registers
  // ************************************************************
  pfsm_cfg_if cfg ();

  pfsm_regs u_regs (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .cfg     (cfg.regs)
  );

  // ************************************************************
  // Mode decode
  // ************************************************************
  pfsm_pkg::pfsm_mode_e mode;
  pfsm_pkg::pfsm_grp_e  grp_a;
  pfsm_pkg::pfsm_grp_e  grp_b;
  logic [5:0]           addr_sel;

  assign mode     = pfsm_pkg::pfsm_mode_e'(
                      cfg.ext_bus_select[pfsm_pkg::MODE_LSB +: pfsm_pkg::MODE_W]);
  assign addr_sel = cfg.ext_bus_select[pfsm_pkg::ADDR_SEL_N-1:0];

  // Code 0 and reserved code 7 leave every flag low
  wire ded_on = mode == pfsm_pkg::PP_MODE1 || mode == pfsm_pkg::PP_MODE6;
  wire a_ap2  = mode == pfsm_pkg::PP_MODE1 || mode == pfsm_pkg::PP_MODE4 ||
                mode == pfsm_pkg::PP_MODE6;
  wire a_gpl  = mode == pfsm_pkg::PP_MODE2;
  wire a_sif  = mode == pfsm_pkg::PP_MODE3 || mode == pfsm_pkg::PP_MODE5;
  wire b_uart = mode == pfsm_pkg::PP_MODE1 || mode == pfsm_pkg::PP_MODE4 ||
                mode == pfsm_pkg::PP_MODE5;
  wire b_gpl  = mode == pfsm_pkg::PP_MODE2;
  wire b_ap3  = mode == pfsm_pkg::PP_MODE3 || mode == pfsm_pkg::PP_MODE6;

  assign grp_a = a_ap2 ? pfsm_pkg::GRP_PRIMARY : a_gpl ? pfsm_pkg::GRP_GPL :
                 a_sif ? pfsm_pkg::GRP_ALT : pfsm_pkg::GRP_NONE;
  assign grp_b = b_uart ? pfsm_pkg::GRP_PRIMARY : b_gpl ? pfsm_pkg::GRP_GPL :
                 b_ap3 ? pfsm_pkg::GRP_ALT : pfsm_pkg::GRP_NONE;

  assign cfg.route_status = {11'h000, grp_b, grp_a, ded_on};

  // ************************************************************
  // Serial interface pins
  // ************************************************************
  genvar k;
  for (k = 0; k < pfsm_pkg::SIF_N; k++) begin : g_sif
    localparam int unsigned DP = pfsm_pkg::SIF_DED_PIN[k];
    assign pp_pin_out[DP] = ded_on & sif_out[k];
    assign pp_pin_oe[DP]  = ded_on & sif_oe[k];
    if (k < pfsm_pkg::PORT_N) begin : g_shared
      // Dedicated pins win when both paths could apply
      assign sif_in[k] = ded_on ? pp_pin_in[DP] :
                         a_sif  ? pp_pin_in[pfsm_pkg::GRP_A_PIN0 + k] :
                                  pfsm_pkg::SIF_IDLE[k];
    end else begin : g_only
      assign sif_in[k] = ded_on ? pp_pin_in[DP] : pfsm_pkg::SIF_IDLE[k];
    end
  end

  // ************************************************************
  // Dedicated general lines 12 to 17
  // ************************************************************
  for (k = 0; k < pfsm_pkg::GPL_DED_N; k++) begin : g_gded
    localparam int unsigned P = pfsm_pkg::GPL_DED_PIN0 + k;
    localparam int unsigned G = pfsm_pkg::GPL_DED_FIRST + k;
    assign pp_pin_out[P] = ded_on & gpl_out[G];
    assign pp_pin_oe[P]  = ded_on & gpl_oe[G];
    assign gpl_in[G]     = ded_on & pp_pin_in[P];
  end

  // ************************************************************
  // Shared groups A and B
  // ************************************************************
  for (k = 0; k < pfsm_pkg::PORT_N; k++) begin : g_grp
    localparam int unsigned PA = pfsm_pkg::GRP_A_PIN0 + k;
    localparam int unsigned PB = pfsm_pkg::GRP_B_PIN0 + k;
    localparam int unsigned GA = pfsm_pkg::GPL_A[k];
    localparam int unsigned GB = pfsm_pkg::GPL_B_FIRST + k;
    assign pp_pin_out[PA] = a_ap2 ? ap2_out[k] : a_gpl ? gpl_out[GA] :
                            a_sif ? sif_out[k] : 1'b0;
    assign pp_pin_oe[PA]  = a_ap2 ? ap2_oe[k] : a_gpl ? gpl_oe[GA] :
                            a_sif ? sif_oe[k] : 1'b0;
    assign ap2_in[k]      = a_ap2 ? pp_pin_in[PA] : pfsm_pkg::AUD_IDLE[k];
    assign gpl_in[GA]     = a_gpl & pp_pin_in[PA];
    assign pp_pin_out[PB] = b_uart ? uart_out[k] : b_gpl ? gpl_out[GB] :
                            b_ap3 ? ap3_out[k] : 1'b0;
    assign pp_pin_oe[PB]  = b_uart ? uart_oe[k] : b_gpl ? gpl_oe[GB] :
                            b_ap3 ? ap3_oe[k] : 1'b0;
    assign uart_in[k]     = b_uart ? pp_pin_in[PB] : pfsm_pkg::UART_IDLE[k];
    assign ap3_in[k]      = b_ap3 ? pp_pin_in[PB] : pfsm_pkg::AUD_IDLE[k];
    assign gpl_in[GB]     = b_gpl & pp_pin_in[PB];
  end

  // ************************************************************
  // Address line pins
  // ************************************************************
  for (k = 0; k < pfsm_pkg::ADDR_SEL_N; k++) begin : g_addr
    localparam int unsigned G = pfsm_pkg::GPL_ADDR_FIRST + k;
    // Memory controller keeps its address when the bit is clear
    assign addr_pin_out[k] = addr_sel[k] ? gpl_out[G] : ext_addr_out[k];
    assign addr_pin_oe[k]  = addr_sel[k] ? gpl_oe[G] : ext_addr_oe[k];
    assign gpl_in[G]       = addr_sel[k] & pp_pin_zero_guard(addr_pin_in[k]);
  end

  // Lines without a pin in this block read low
  assign gpl_in[pfsm_pkg::GPL_DED_FIRST-1:0] = 12'h000;

  function automatic logic pp_pin_zero_guard(input logic v);
    return v;
  endfunction

  // ************************************************************
  // Pad controls
  // ************************************************************
  // Test reset pull-down has no bit here and stays always on
  assign pull_disable = {cfg.pull_inhibit_third, cfg.pull_inhibit_second,
                         cfg.pull_inhibit_first};
  assign clock_output_pin_slow  = cfg.output_slew_select[pfsm_pkg::SLEW_CLOCK_OUT_BIT];
  assign ext_mem_interface_slow = cfg.output_slew_select[pfsm_pkg::SLEW_EXT_MEM_BIT];

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ebs_wr;
    psel && penable && pwrite && paddr == pfsm_pkg::ADDR_EXT_BUS_SELECT;
  endsequence

  sequence s_pull_wr;
    psel && penable && pwrite && paddr == pfsm_pkg::ADDR_PULL_INHIBIT_FIRST;
  endsequence

  sequence s_slew_wr;
    psel && penable && pwrite && paddr == pfsm_pkg::ADDR_OUTPUT_SLEW_SELECT;
  endsequence

  AST_ONE_SOURCE: assert property (
    $changed(cfg.ext_bus_select) |->
      $past(psel && penable && pwrite && paddr == pfsm_pkg::ADDR_EXT_BUS_SELECT))
    else $error("Selection register changed without a write");

  AST_MODE_FIELD: assert property (
    s_ebs_wr |=> mode == $past(pwdata[14:12]) && addr_sel == $past(pwdata[5:0]))
    else $error("Route mode does not follow bits 14 to 12");

  AST_MODE0_QUIET: assert property (
    mode == pfsm_pkg::PP_MODE0 |-> pp_pin_oe == 21'h00000 && pp_pin_out == 21'h00000)
    else $error("Mode 0 drives a parallel pin");

  AST_RSVD_QUIET: assert property (
    mode == pfsm_pkg::PP_RSVD7 |-> pp_pin_oe == 21'h00000 && sif_in == pfsm_pkg::SIF_IDLE
                                   && uart_in == pfsm_pkg::UART_IDLE)
    else $error("Reserved mode routes a function");

  AST_GRP_A: assert property (
    a_sif |-> pp_pin_out[12:9] == sif_out[3:0] && sif_in[3:0] == pp_pin_in[12:9])
    else $error("Group A serial routing wrong");

  AST_GRP_B: assert property (
    mode == pfsm_pkg::PP_MODE5 |-> pp_pin_out[16:13] == uart_out && uart_in == pp_pin_in[16:13])
    else $error("Group B uart routing wrong");

  AST_DED: assert property (
    mode == pfsm_pkg::PP_MODE1 |-> pp_pin_out[8:3] == gpl_out[17:12]
                                   && pp_pin_out[20:17] == {sif_out[6:4], sif_out[1]}
                                   && pp_pin_out[12:9] == ap2_out)
    else $error("Mode 1 dedicated routing wrong");

  AST_IDLE_IN: assert property (
    !ded_on && !a_sif |-> sif_in == pfsm_pkg::SIF_IDLE)
    else $error("Unrouted serial input not idle");

  AST_ADDR20: assert property (
    addr_sel[5] |-> addr_pin_out[5] == gpl_out[26] && gpl_in[26] == addr_pin_in[5])
    else $error("Address pin 20 select wrong");

  AST_ADDR15: assert property (
    !addr_sel[0] |-> addr_pin_out[0] == ext_addr_out[0] && !gpl_in[21])
    else $error("Address pin 15 select wrong");

  AST_PULL: assert property (
    s_pull_wr |=> pull_disable[15:0] == $past(pwdata[15:0]))
    else $error("Pull inhibit write lost");

  AST_SLEW: assert property (
    s_slew_wr |=> clock_output_pin_slow == $past(pwdata[0])
                  && ext_mem_interface_slow == $past(pwdata[1]))
    else $error("Slew write lost");

  AST_SLEW_ONLY: assert property (
    $changed(cfg.output_slew_select) |->
      $past(psel && penable && pwrite && paddr == pfsm_pkg::ADDR_OUTPUT_SLEW_SELECT))
    else $error("Slew register changed without a write");

  // Every address pin at once, so a swapped bit pair cannot hide
  AST_ADDR_MIX: assert property (
    addr_pin_out == ((addr_sel & gpl_out[26:21]) | (~addr_sel & ext_addr_out))
    && addr_pin_oe == ((addr_sel & gpl_oe[26:21]) | (~addr_sel & ext_addr_oe))
    && gpl_in[26:21] == (addr_sel & addr_pin_in))
    else $error("Address pin selection wrong");

  AST_GPL_PINS: assert property (
    mode == pfsm_pkg::PP_MODE2 |-> pp_pin_out[16:9] == {gpl_out[31:27], gpl_out[20:18]}
                                   && {gpl_in[31:27], gpl_in[20:18]} == pp_pin_in[16:9])
    else $error("General line routing wrong");

  AST_AP3: assert property (
    b_ap3 |-> pp_pin_out[16:13] == ap3_out && ap3_in == pp_pin_in[16:13]
              && uart_in == pfsm_pkg::UART_IDLE)
    else $error("Audio port 3 routing wrong");

  AST_AP2: assert property (
    a_ap2 |-> pp_pin_oe[12:9] == ap2_oe && ap2_in == pp_pin_in[12:9])
    else $error("Audio port 2 routing wrong");

  AST_DED_IN: assert property (
    ded_on |-> gpl_in[17:12] == pp_pin_in[8:3] && sif_in[6:4] == pp_pin_in[20:18]
               && pp_pin_oe[2:0] == {sif_oe[3], sif_oe[2], sif_oe[0]})
    else $error("Dedicated pin inputs wrong");

  AST_NO_DED: assert property (
    !ded_on |-> pp_pin_oe[8:0] == 9'h000 && pp_pin_oe[20:17] == 4'h0
                && gpl_in[17:12] == 6'h00)
    else $error("Dedicated pins active outside their modes");

  AST_UART_IDLE: assert property (
    !b_uart |-> uart_in == pfsm_pkg::UART_IDLE)
    else $error("Unrouted uart input not idle");

  AST_AP2_IDLE: assert property (
    !a_ap2 |-> ap2_in == pfsm_pkg::AUD_IDLE)
    else $error("Unrouted audio input not idle");

endmodule

/* tb/pfsm_pad_model.sv */
// Purpose: Pad ring and board drivers seen from the shared pins
// Assumes: An undriven pin follows the board-level driver on ext
// Notes:   Board drivers are present on every pin, so pulls may be off
`timescale 1ns/10ps

module pfsm_pad_model (
  input  wire logic [20:0] pp_out,
  input  wire logic [20:0] pp_oe,
  input  wire logic [20:0] pp_ext,
  output logic      [20:0] pp_in,
  input  wire logic [5:0]  a_out,
  input  wire logic [5:0]  a_oe,
  input  wire logic [5:0]  a_ext,
  output logic      [5:0]  a_in
);
  // Chip drive wins; otherwise the board driver sets the level
  assign pp_in = (pp_oe & pp_out) | (~pp_oe & pp_ext);
  assign a_in  = (a_oe & a_out) | (~a_oe & a_ext);
endmodule

/* tb/pfsm_top_tb.sv */
// Purpose: Self-checking bench for the pin function select mux
// Assumes: Zero-wait APB slave, routing combinational from registers
// Notes:   Mode rows hold the expected group sources and status code
`timescale 1ns/10ps

module pfsm_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd, gpl_out, gpl_oe, gpl_in;
  logic [6:0]  sif_out, sif_oe, sif_in;
  logic [3:0]  ap2_out, ap2_oe, ap2_in, ap3_out, ap3_oe, ap3_in, uart_out, uart_oe, uart_in;
  logic [5:0]  ext_addr_out, ext_addr_oe, addr_pin_out, addr_pin_oe, addr_pin_in, a_ext, p, ao, ae;
  logic [20:0] pp_pin_out, pp_pin_oe, pp_pin_in, pp_ext;
  logic [47:0] pull_disable;
  logic [41:0] e;
  logic        clock_output_pin_slow, ext_mem_interface_slow;
  int          err_count, total_checks, cycles;
  localparam logic [15:0] ST_ADR = 16'h7004;
  localparam logic [4:0]  ROWS [8] = '{5'h00, 5'h15, 5'h0A, 5'h0F, 5'h05, 5'h0D, 5'h17, 5'h00};
  localparam logic [15:0] ADR [5] = '{pfsm_pkg::ADDR_EXT_BUS_SELECT,
    pfsm_pkg::ADDR_OUTPUT_SLEW_SELECT, pfsm_pkg::ADDR_PULL_INHIBIT_FIRST, 16'h7060, 16'h7064};
  localparam logic [15:0] MSK [5] = '{16'h703F, 16'h0003, 16'hFFFF, 16'hFFFF, 16'hFFFF};

  pfsm_top i_pfsm_top (.*);
  pfsm_pad_model i_pfsm_pad_model (.pp_out(pp_pin_out), .pp_oe(pp_pin_oe), .pp_ext(pp_ext),
    .pp_in(pp_pin_in), .a_out(addr_pin_out), .a_oe(addr_pin_oe), .a_ext(a_ext), .a_in(addr_pin_in));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic final_report();
    if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, well above the 150 or so cycles the run needs
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      final_report();
    end
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask

  // Mask and values of the parallel pins for one row
  function automatic logic [41:0] expv(input logic [4:0] r);
    logic [20:0] m, o;
    m = '0;
    o = '0;
    if (r[4]) begin
      m[8:0] = '1;
      m[20:17] = '1;
      o[8:0] = {gpl_out[17:12], sif_out[3], sif_out[2], sif_out[0]};
      o[20:17] = {sif_out[6:4], sif_out[1]};
    end
    case (r[3:2])
      2'd1: o[12:9] = ap2_out;
      2'd2: o[12:9] = {gpl_out[27], gpl_out[20:18]};
      2'd3: o[12:9] = sif_out[3:0];
      default: ;
    endcase
    case (r[1:0])
      2'd1: o[16:13] = uart_out;
      2'd2: o[16:13] = gpl_out[31:28];
      2'd3: o[16:13] = ap3_out;
      default: ;
    endcase
    m[12:9] = {4{r[3:2] != 2'd0}};
    m[16:13] = {4{r[1:0] != 2'd0}};
    return {m, o};
  endfunction

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {sif_oe, ap2_oe, ap3_oe, uart_oe, gpl_oe, ext_addr_oe} = '1;
    {sif_out, ap2_out, ap3_out, uart_out} = {7'h36, 4'h9, 4'h5, 4'hC};
    {gpl_out, ext_addr_out, pp_ext, a_ext} = {32'h3C5AF0E1, 6'h19, 21'h15A5C3, 6'h26};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ADR[i], 32'h0);
      chk(rd, 48'h0, "reset value");
      apb(1'b1, ADR[i], 32'hFFFF);
      apb(1'b0, ADR[i], 32'h0);
      chk(rd, MSK[i], "read back");
    end
    for (int m = 0; m < 8; m++) begin
      // Peripherals here hold no state, so each route change is checked against the same fixed drive values
      apb(1'b1, ADR[0], 32'(m) << 12);
      apb(1'b0, ST_ADR, 32'h0);
      chk(rd, {ROWS[m][1:0], ROWS[m][3:2], ROWS[m][4]}, "route status");
      e = expv(ROWS[m]);
      chk(pp_pin_oe, e[41:21], "pin enables");
      chk(pp_pin_out & e[41:21], e[20:0], "pin values");
    end
    // Unrouted peripheral inputs rest idle while general lines own the pins
    apb(1'b1, ADR[0], 32'h2000);
    chk({sif_in, uart_in, ap2_in, ap3_in}, {pfsm_pkg::SIF_IDLE, pfsm_pkg::UART_IDLE, 8'h0}, "idle");
    @(posedge pclk);
    ap3_oe <= 4'h0;
    ap2_oe <= 4'h0;
    apb(1'b1, ADR[0], 32'h3000);
    chk({uart_in, ap3_in}, {pfsm_pkg::UART_IDLE, pp_ext[16:13]}, "mode 3 inputs");
    apb(1'b1, ADR[0], 32'h1000);
    chk({ap2_in, uart_in, sif_in, gpl_in[17:12]}, {pp_ext[12:9], uart_out, sif_out,
        gpl_out[17:12]}, "mode 1 inputs");
    @(posedge pclk);
    gpl_oe <= 32'h0F00_0000;
    ext_addr_oe <= 6'h33;
    for (int k = 0; k < 3; k++) begin
      p = (k == 0) ? 6'h2A : (k == 1) ? 6'h15 : 6'h3F;
      apb(1'b1, ADR[0], 32'(p));
      ao = (p & gpl_out[26:21]) | (~p & ext_addr_out);
      ae = (p & gpl_oe[26:21]) | (~p & ext_addr_oe);
      chk({addr_pin_out, addr_pin_oe}, {ao, ae}, "address pins");
      chk(gpl_in[26:21], p & ((ae & ao) | (~ae & a_ext)), "address pin inputs");
    end
    // Pulls off on a mixed pattern of pads across all three inhibit registers
    apb(1'b1, ADR[2], 32'h1234);
    apb(1'b1, ADR[3], 32'h5678);
    apb(1'b1, ADR[4], 32'h9ABC);
    chk(pull_disable, 48'h9ABC_5678_1234, "pull inhibit");
    for (int s = 1; s < 3; s++) begin
      apb(1'b1, ADR[1], 32'(s));
      chk({ext_mem_interface_slow, clock_output_pin_slow}, 48'(s), "slew");
    end
    apb(1'b0, 16'h0100, 32'h0);
    chk({er, rd}, 48'h1_0000_0000, "unmapped read");
    apb(1'b1, ADR[0] + 16'h1, 32'h1000);
    chk(er, 48'h1, "unaligned write");
    apb(1'b1, ST_ADR, 32'hFFFF);
    chk(er, 48'h0, "status write");
    apb(1'b0, ADR[0], 32'h0);
    chk(rd, 48'h3F, "selection kept");
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    chk({pp_pin_oe, addr_pin_out}, {21'h0, ext_addr_out}, "mid-run reset");
    chk(pull_disable, 48'h0, "pulls after reset");
    chk({ext_mem_interface_slow, clock_output_pin_slow}, 48'h0, "slew after reset");
    // Two edges in reset, so no sampled-value check compares across the clear
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADR[0], 32'h0);
    chk(rd, 48'h0, "selection after reset");
    final_report();
  end
endmodule
